/* File: logic/liu_strap_and_driver_monitor.sv */
// One line channel: strap decoding, line coder, reset qualifier, driver alarm
`timescale 1ns/100ps
`default_nettype none
`include "liu_strap_params.svh"
module liu_strap_and_driver_monitor (
  input wire logic clock_in, // 125 MHz system clock
  input wire logic rst_n_in, // Power-on reset, async, active low
  input wire logic hw_reset_n_in, // Hardware reset pin, active low
  input wire logic host_mode_in, // High selects host mode
  input wire liu_strap_pkg::strap_t straps_in, // Configuration strap pins
  input wire liu_strap_pkg::line_cfg_t host_cfg_in, // Host channel settings
  input wire logic rx_termination_pin_override_in, // Global override bit
  input wire logic rx_termination_reg_bit_in, // Channel termination bit
  input wire liu_strap_pkg::line_code_t line_code_in, // Single rail line code
  input wire logic in_circuit_test_n_in, // Low releases all outputs
  input wire logic transmit_clock_in, // Transmit clock, sampled
  input wire logic tx_data_in, // Single rail transmit data
  input wire liu_strap_pkg::rail_pair_t tx_rails_in, // Dual rail transmit data
  input wire logic tx_pulse_seen_in, // Output buffer pulse detector
  input wire logic rx_clock_in, // Recovered receive clock, sampled
  input wire liu_strap_pkg::rail_pair_t rx_rails_in, // Sliced receive pulses
  output liu_strap_pkg::line_cfg_t line_cfg_out, // Decoded settings
  output liu_strap_pkg::rail_pair_t tx_rails_out, // To the line driver
  output logic rx_data_out, // Single rail receive data
  output liu_strap_pkg::rail_pair_t rx_rails_out, // Dual rail receive data
  output logic driver_activity_alarm_out, // Driver activity alarm
  output logic pins_oe_out // Enable for every output pin
);
  import liu_strap_pkg::*;

  localparam line_cfg_t CFG_DEFAULT = line_cfg_t'(`CFG_RESET);
  localparam logic [`ZRUN_W-1:0] B8ZS_LAST = `ZRUN_W'(`B8ZS_RUN - 1);
  localparam logic [`ZRUN_W-1:0] HDB3_LAST = `ZRUN_W'(`HDB3_RUN - 1);
  localparam int TOP = `SUB_DEPTH - 1;

  function automatic logic rising(input logic now, input logic was);
    return now & ~was;
  endfunction

  function automatic rail_pair_t polar(input logic positive);
    rail_pair_t p;
    p.pos = positive;
    p.neg = ~positive;
    return p;
  endfunction

  logic regs_clear;
  logic tx_tick;
  logic rx_tick;

  hw_reset_qualifier u_reset (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .hw_reset_n_in(hw_reset_n_in),
    .regs_clear_out(regs_clear)
  );

  // Sampled clocks for edge detection
  logic txc_q, txc_d, rxc_q, rxc_d;

  always_comb begin
    txc_d = transmit_clock_in;
    rxc_d = rx_clock_in;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
    end else begin
      txc_q <= txc_d;
      rxc_q <= rxc_d;
    end
  end

  assign tx_tick = rising(transmit_clock_in, txc_q);
  assign rx_tick = rising(rx_clock_in, rxc_q);

  // Channel configuration
  line_cfg_t cfg_q, cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (regs_clear) begin
      cfg_d = CFG_DEFAULT;
    end else if (host_mode_in) begin
      cfg_d = host_cfg_in;
      // Hard switch for redundancy without touching every channel register
      cfg_d.rx_internal = rx_termination_pin_override_in ?
          straps_in.rx_termination_select : rx_termination_reg_bit_in;
    end else begin
      cfg_d.single_rail = straps_in.rail_format_select;
      cfg_d.rx_internal = straps_in.rx_termination_select;
      cfg_d.tx_internal = straps_in.tx_termination_select;
      cfg_d.impedance = impedance_t'({straps_in.impedance_select_hi,
          straps_in.impedance_select_lo});
      cfg_d.gauge_26 = straps_in.gauge_select;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= CFG_DEFAULT;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Transmit encoder: fixed latency so substitutions can reach back in time
  symbol_t sym_q [`SUB_DEPTH];
  symbol_t sym_d [`SUB_DEPTH];
  logic [`ZRUN_W-1:0] zrun_q, zrun_d;
  logic parity_q, parity_d;
  logic last_pol_q, last_pol_d;
  rail_pair_t tx_q, tx_d;
  rail_pair_t enc;

  always_comb begin
    sym_d = sym_q;
    zrun_d = zrun_q;
    parity_d = parity_q;
    last_pol_d = last_pol_q;
    tx_d = tx_q;
    enc = '0;
    if (regs_clear) begin
      sym_d = '{default: SYM_ZERO};
      zrun_d = '0;
      parity_d = 1'b0;
      last_pol_d = 1'b0;
      tx_d = '0;
    end else if (tx_tick) begin
      for (int i = TOP; i > 0; i--) begin
        sym_d[i] = sym_q[i - 1];
      end
      sym_d[0] = tx_data_in ? SYM_MARK : SYM_ZERO;
      if (tx_data_in) begin
        zrun_d = '0;
        parity_d = ~parity_q;
      end else begin
        zrun_d = zrun_q + `ZRUN_W'(1);
      end
      if (!tx_data_in && line_code_in == CODE_B8ZS && zrun_q == B8ZS_LAST) begin
        sym_d[4] = SYM_VIOL;
        sym_d[3] = SYM_MARK;
        sym_d[1] = SYM_VIOL;
        sym_d[0] = SYM_MARK;
        zrun_d = '0;
      end
      if (!tx_data_in && line_code_in == CODE_HDB3 && zrun_q == HDB3_LAST) begin
        sym_d[0] = SYM_VIOL;
        if (!parity_q) begin
          sym_d[3] = SYM_MARK;
        end
        parity_d = 1'b0;
        zrun_d = '0;
      end
      case (sym_q[TOP])
        SYM_MARK: begin
          enc = polar(~last_pol_q);
          last_pol_d = ~last_pol_q;
        end
        SYM_VIOL: begin
          enc = polar(last_pol_q);
        end
        default: begin
          enc = '0;
        end
      endcase
      tx_d = cfg_q.single_rail ? enc : tx_rails_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sym_q <= '{default: SYM_ZERO};
      zrun_q <= '0;
      parity_q <= 1'b0;
      last_pol_q <= 1'b0;
      tx_q <= '0;
    end else begin
      sym_q <= sym_d;
      zrun_q <= zrun_d;
      parity_q <= parity_d;
      last_pol_q <= last_pol_d;
      tx_q <= tx_d;
    end
  end

  // Receive decoder: under B8ZS and HDB3 violations are removed along with their paired marks
  logic [TOP:0] rx_bits_q, rx_bits_d;
  logic [TOP:0] rx_viol_q, rx_viol_d;
  logic rx_pol_q, rx_pol_d;
  logic rx_data_q, rx_data_d;
  rail_pair_t rx_rails_q, rx_rails_d;
  logic rx_mark;
  logic rx_viol;

  assign rx_mark = rx_rails_in.pos | rx_rails_in.neg;
  assign rx_viol = rx_mark && (rx_rails_in.pos == rx_pol_q);

  always_comb begin
    rx_bits_d = rx_bits_q;
    rx_viol_d = rx_viol_q;
    rx_pol_d = rx_pol_q;
    rx_data_d = rx_data_q;
    rx_rails_d = rx_rails_q;
    if (regs_clear) begin
      rx_bits_d = '0;
      rx_viol_d = '0;
      rx_pol_d = 1'b0;
      rx_data_d = 1'b0;
      rx_rails_d = '0;
    end else if (rx_tick) begin
      // Under AMI a violation is a line error and still counts as a one
      rx_bits_d = {rx_bits_q[TOP-1:0], rx_mark && !(rx_viol && line_code_in != CODE_AMI)};
      rx_viol_d = {rx_viol_q[TOP-1:0], rx_viol};
      if (line_code_in == CODE_HDB3 && rx_viol) begin
        rx_bits_d[3] = 1'b0;
      end
      if (line_code_in == CODE_B8ZS && rx_mark && !rx_viol && rx_viol_q[0] && rx_viol_q[3]) begin
        rx_bits_d[0] = 1'b0;
        rx_bits_d[3] = 1'b0;
      end
      if (rx_mark) begin
        rx_pol_d = rx_rails_in.pos;
      end
      rx_data_d = rx_bits_q[TOP];
      rx_rails_d = rx_rails_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_bits_q <= '0;
      rx_viol_q <= '0;
      rx_pol_q <= 1'b0;
      rx_data_q <= 1'b0;
      rx_rails_q <= '0;
    end else begin
      rx_bits_q <= rx_bits_d;
      rx_viol_q <= rx_viol_d;
      rx_pol_q <= rx_pol_d;
      rx_data_q <= rx_data_d;
      rx_rails_q <= rx_rails_d;
    end
  end

  driver_activity_monitor u_monitor (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(regs_clear),
    .tick_in(tx_tick),
    .pulse_in(tx_pulse_seen_in),
    .alarm_out(driver_activity_alarm_out)
  );

  assign line_cfg_out = cfg_q;
  assign tx_rails_out = tx_q;
  assign rx_data_out = rx_data_q;
  assign rx_rails_out = rx_rails_q;
  assign pins_oe_out = in_circuit_test_n_in;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_reg_defaults: assert property (regs_clear |=> cfg_q == CFG_DEFAULT && tx_q == '0
      && !driver_activity_alarm_out) else $error("qualified reset left state");
  a_rail_dual: assert property (!regs_clear && tx_tick && !cfg_q.single_rail
      |=> tx_q == $past(tx_rails_in)) else $error("dual rail data not passed");
  a_b8zs_subst: assert property (!regs_clear && tx_tick && line_code_in == CODE_B8ZS
      && !tx_data_in && zrun_q == B8ZS_LAST |=> sym_q[4] == SYM_VIOL && sym_q[1] == SYM_VIOL
      && zrun_q == '0) else $error("zero run not substituted");
  a_hw_terms: assert property (!regs_clear && !host_mode_in |=>
      cfg_q.rx_internal == $past(straps_in.rx_termination_select)
      && cfg_q.tx_internal == $past(straps_in.tx_termination_select))
      else $error("termination strap ignored");
  a_host_override: assert property (
      !regs_clear && host_mode_in && rx_termination_pin_override_in
      |=> cfg_q.rx_internal == $past(straps_in.rx_termination_select))
      else $error("override did not take strap");
  a_imp_decode: assert property (!regs_clear && !host_mode_in |=>
      cfg_q.impedance == impedance_t'($past({straps_in.impedance_select_hi,
      straps_in.impedance_select_lo})) && cfg_q.gauge_26 == $past(straps_in.gauge_select))
      else $error("strap decode wrong");
  a_ict_release: assert property (!in_circuit_test_n_in |-> !pins_oe_out)
      else $error("outputs enabled in test");
  c_single_rail: cover property (cfg_q.single_rail && tx_tick && tx_q != '0);
  c_hdb3_viol: cover property (line_code_in == CODE_HDB3 && tx_tick && sym_q[TOP] == SYM_VIOL);
endmodule
`default_nettype wire

/* File: inc/liu_strap_params.svh */
// Timing counts, limits and reset values of the strap and monitor block
`ifndef LIU_STRAP_PARAMS_SVH
`define LIU_STRAP_PARAMS_SVH

`define CLK_PERIOD_NS 8
`define HW_RESET_MIN_NS 10000
`define HW_RESET_CYCLES ((`HW_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 11
`define NO_PULSE_LIMIT 128
`define MON_CNT_W 8
`define SUB_DEPTH 8
`define B8ZS_RUN 8
`define HDB3_RUN 4
`define ZRUN_W 4
`define CFG_RESET 6'h00

`endif

/* File: inc/liu_strap_pkg.sv */
// Types shared by the strap decoder, line coder and receive decoder
package liu_strap_pkg;

  // Order matches the two-bit impedance strap code
  typedef enum logic [1:0] {IMP_100_OHM, IMP_110_OHM, IMP_75_OHM, IMP_120_OHM} impedance_t;

  typedef enum logic [1:0] {CODE_AMI, CODE_B8ZS, CODE_HDB3} line_code_t;

  typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_VIOL} symbol_t;

  typedef struct packed {
    logic single_rail;
    logic rx_internal;
    logic tx_internal;
    impedance_t impedance;
    logic gauge_26;
  } line_cfg_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_t;

  typedef struct packed {
    logic rail_format_select;
    logic rx_termination_select;
    logic tx_termination_select;
    logic impedance_select_hi;
    logic impedance_select_lo;
    logic gauge_select;
  } strap_t;

endpackage

/* File: logic/hw_reset_qualifier.sv */
// Qualifies the hardware reset pin against its minimum low time
`timescale 1ns/100ps
`default_nettype none
`include "liu_strap_params.svh"
module hw_reset_qualifier (
  input wire logic clock_in, // System clock
  input wire logic rst_n_in, // Power-on reset, async, active low
  input wire logic hw_reset_n_in, // Hardware reset pin, active low
  output logic regs_clear_out // High while a qualified reset is held
);
  localparam logic [`RST_CNT_W-1:0] LIMIT = `RST_CNT_W'(`HW_RESET_CYCLES);

  logic [`RST_CNT_W-1:0] cnt_q, cnt_d;
  logic clear_q, clear_d;

  // Short glitches on the pin never reach the registers
  always_comb begin
    cnt_d = '0;
    clear_d = 1'b0;
    if (!hw_reset_n_in) begin
      cnt_d = (cnt_q == LIMIT) ? cnt_q : cnt_q + `RST_CNT_W'(1);
      clear_d = (cnt_d == LIMIT);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      clear_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clear_q <= clear_d;
    end
  end

  assign regs_clear_out = clear_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_qualify: assert property (
      $rose(clear_q) |-> $past(cnt_q) == LIMIT - `RST_CNT_W'(1) && $past(!hw_reset_n_in))
      else $error("reset cleared before minimum low time");
  a_reset_release: assert property (hw_reset_n_in |=> !clear_q && cnt_q == '0)
      else $error("qualified reset outlived the pin");
  c_reset_seen: cover property ($rose(clear_q));
endmodule
`default_nettype wire

/* File: logic/driver_activity_monitor.sv */
// Counts transmit clock cycles without an output pulse and raises the alarm
`timescale 1ns/100ps
`default_nettype none
`include "liu_strap_params.svh"
module driver_activity_monitor (
  input wire logic clock_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic clear_in, // Synchronous return to defaults
  input wire logic tick_in, // One transmit clock cycle elapsed
  input wire logic pulse_in, // Output buffer saw a pulse this cycle
  output logic alarm_out // Driver activity alarm, registered
);
  localparam logic [`MON_CNT_W-1:0] LIMIT = `MON_CNT_W'(`NO_PULSE_LIMIT);
  localparam logic [`MON_CNT_W-1:0] SAT = LIMIT + `MON_CNT_W'(1);

  logic [`MON_CNT_W-1:0] cnt_q, cnt_d;
  logic alarm_q, alarm_d;

  always_comb begin
    cnt_d = cnt_q;
    alarm_d = alarm_q;
    if (clear_in) begin
      cnt_d = '0;
      alarm_d = 1'b0;
    end else if (tick_in) begin
      if (pulse_in) begin
        cnt_d = '0;
        alarm_d = 1'b0;
      end else begin
        // Saturate so a dead driver keeps the alarm up indefinitely
        cnt_d = (cnt_q == SAT) ? cnt_q : cnt_q + `MON_CNT_W'(1);
        alarm_d = (cnt_d > LIMIT);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      alarm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      alarm_q <= alarm_d;
    end
  end

  assign alarm_out = alarm_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_alarm_raise: assert property (!clear_in && tick_in && !pulse_in && cnt_q == LIMIT
      |=> alarm_q) else $error("alarm missing after silent limit");
  a_alarm_early: assert property (alarm_q |-> cnt_q == SAT)
      else $error("alarm raised before limit");
  a_alarm_hold: assert property (
      alarm_q && !clear_in && !(tick_in && pulse_in) |=> alarm_q)
      else $error("alarm dropped without a pulse");
  a_pulse_restart: assert property (
      !clear_in && tick_in && pulse_in |=> cnt_q == '0 && !alarm_q)
      else $error("pulse did not restart the count");
  c_alarm_rise: cover property ($rose(alarm_q));
  c_alarm_fall: cover property (alarm_q ##1 !alarm_q);
endmodule
`default_nettype wire

/* File: dv/line_far_end.sv */
// Far-end model: framer side giving transmit and receive ticks with their data
`timescale 1ns/100ps
`default_nettype none
module line_far_end (
  input wire logic clock_in, // System clock
  output logic transmit_clock_out, // Transmit clock level
  output logic tx_data_out, // Single rail transmit data
  output var liu_strap_pkg::rail_pair_t tx_rails_out, // Dual rail transmit data
  output logic tx_pulse_seen_out, // Output buffer pulse detector
  output logic rx_clock_out, // Receive clock level
  output var liu_strap_pkg::rail_pair_t rx_rails_out // Sliced receive pulses
);
  import liu_strap_pkg::*;
  initial begin
    transmit_clock_out = 1'h0;
    tx_data_out = 1'h0;
    tx_rails_out = 2'h0;
    tx_pulse_seen_out = 1'h0;
    rx_clock_out = 1'h0;
    rx_rails_out = 2'h0;
  end
  // One tick on both clocks; clocks stand low between ticks
  task automatic tick(input logic pulse, input logic data, input rail_pair_t tx,
                      input rail_pair_t rx);
    @(posedge clock_in);
    transmit_clock_out <= 1'h1;
    rx_clock_out <= 1'h1;
    tx_data_out <= data;
    tx_rails_out <= tx;
    tx_pulse_seen_out <= pulse;
    rx_rails_out <= rx;
    @(posedge clock_in);
    transmit_clock_out <= 1'h0;
    rx_clock_out <= 1'h0;
    // Hold is over: show the inverse so a late sample cannot pass by luck
    tx_data_out <= ~data;
    tx_rails_out <= ~tx;
    tx_pulse_seen_out <= ~pulse;
    rx_rails_out <= ~rx;
    @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

/* File: dv/test_liu_strap_and_driver_monitor.sv */
// Self-checking bench for strap decoding, line coder and driver alarm
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_liu_strap_and_driver_monitor;
  import liu_strap_pkg::*;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic hw_reset_n_in = 1'h1;
  logic host_mode_in = 1'h0;
  strap_t straps_in = 6'h00;
  line_cfg_t host_cfg_in = 6'h00;
  logic ovr = 1'h0;
  logic reg_bit = 1'h0;
  line_code_t line_code_in = CODE_AMI;
  logic ict_n = 1'h1;
  logic transmit_clock, tx_data, tx_pulse_seen, rx_clock;
  rail_pair_t tx_rails_in, rx_rails_in, tx_rails_out, rx_rails_out;
  line_cfg_t line_cfg_out;
  line_cfg_t exp_c;
  logic rx_data_out, alarm, pins_oe;
  int n_fail = 0;
  int compares = 0;
  int cnt = 0;
  logic dual = 1'h1;
  // Single rail stimulus per code (bit k on tick k) and rail pairs seen on ticks 8..15
  logic [15:0] code_data [3] = '{16'hffff, 16'hff00, 16'hfff0};
  logic [15:0] code_rails [3] = '{16'h9999, 16'h0189, 16'h8266};

  always #4 clock_in = ~clock_in;

  liu_strap_and_driver_monitor i_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .hw_reset_n_in(hw_reset_n_in),
    .host_mode_in(host_mode_in), .straps_in(straps_in), .host_cfg_in(host_cfg_in),
    .rx_termination_pin_override_in(ovr), .rx_termination_reg_bit_in(reg_bit),
    .line_code_in(line_code_in), .in_circuit_test_n_in(ict_n),
    .transmit_clock_in(transmit_clock), .tx_data_in(tx_data), .tx_rails_in(tx_rails_in),
    .tx_pulse_seen_in(tx_pulse_seen), .rx_clock_in(rx_clock), .rx_rails_in(rx_rails_in),
    .line_cfg_out(line_cfg_out), .tx_rails_out(tx_rails_out), .rx_data_out(rx_data_out),
    .rx_rails_out(rx_rails_out), .driver_activity_alarm_out(alarm), .pins_oe_out(pins_oe));

  line_far_end i_far (
    .clock_in(clock_in), .transmit_clock_out(transmit_clock), .tx_data_out(tx_data),
    .tx_rails_out(tx_rails_in), .tx_pulse_seen_out(tx_pulse_seen), .rx_clock_out(rx_clock),
    .rx_rails_out(rx_rails_in));

  function automatic line_cfg_t exp_cfg(input logic host, input strap_t s, input line_cfg_t h,
                                        input logic o, input logic r);
    line_cfg_t e;
    if (host) begin
      e = h;
      e.rx_internal = o ? s.rx_termination_select : r;
    end else begin
      e.single_rail = s.rail_format_select;
      e.rx_internal = s.rx_termination_select;
      e.tx_internal = s.tx_termination_select;
      e.impedance = impedance_t'({s.impedance_select_hi, s.impedance_select_lo});
      e.gauge_26 = s.gauge_select;
    end
    return e;
  endfunction

  // One transmit and receive tick, then the alarm against a no-pulse count
  task automatic step(input logic pulse, input logic data, input rail_pair_t tx,
                      input rail_pair_t rx);
    i_far.tick(pulse, data, tx, rx);
    #1;
    cnt = pulse ? 0 : cnt + 1;
    `CHK("alarm", cnt > 128, alarm)
    `CHK("rx rails", rx, rx_rails_out)
    if (dual) `CHK("tx rails", tx, tx_rails_out)
  endtask

  // Hardware reset pin low for n+1 samples
  task automatic hold_hw(input int n, input logic clears);
    @(posedge clock_in);
    hw_reset_n_in <= 1'h0;
    repeat (n) @(posedge clock_in);
    #1;
    if (clears) `CHK("cleared cfg", 6'h00, line_cfg_out)
    if (clears) `CHK("cleared alarm", 1'h0, alarm)
    @(posedge clock_in);
    hw_reset_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    #1;
    exp_c = exp_cfg(1'h0, straps_in, host_cfg_in, ovr, reg_bit);
    `CHK("cfg after pin", exp_c, line_cfg_out)
    `CHK("alarm after pin", ~clears, alarm)
    if (clears) cnt = 0;
  endtask

  task automatic results();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    results();
  end

  initial begin
    void'($urandom(63692));
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'h1;
    @(posedge clock_in);
    #1;
    `CHK("reset cfg", 6'h00, line_cfg_out)
    // Every impedance code in hardware mode first, then random mixes of both modes
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_in);
      host_mode_in <= (i < 4) ? 1'h0 : 1'($urandom);
      straps_in <= (i < 4) ? strap_t'(6'(i << 1)) : strap_t'(6'($urandom));
      host_cfg_in <= line_cfg_t'(6'($urandom));
      ovr <= 1'($urandom);
      reg_bit <= 1'($urandom);
      ict_n <= 1'($urandom);
      repeat (2) @(posedge clock_in);
      #1;
      exp_c = exp_cfg(host_mode_in, straps_in, host_cfg_in, ovr, reg_bit);
      `CHK("cfg", exp_c, line_cfg_out)
      `CHK("pins oe", ict_n, pins_oe)
    end
    @(posedge clock_in);
    host_mode_in <= 1'h0;
    straps_in <= strap_t'(6'h1f);
    ict_n <= 1'h1;
    // Past the no-pulse limit, one pulse, then the count must start over
    for (int i = 0; i < 132; i++) begin
      step(1'h0, 1'($urandom), rail_pair_t'(2'($urandom)), rail_pair_t'(2'($urandom)));
    end
    step(1'h1, 1'($urandom), rail_pair_t'(2'($urandom)), rail_pair_t'(2'($urandom)));
    for (int i = 0; i < 129; i++) begin
      step(1'h0, 1'($urandom), rail_pair_t'(2'($urandom)), rail_pair_t'(2'($urandom)));
    end
    hold_hw(1248, 1'h0);
    hold_hw(1260, 1'h1);
    // Single rail coder per code, fresh polarity each time; the coded line is fed to the receiver
    dual = 1'h0;
    for (int c = 0; c < 3; c++) begin
      @(posedge clock_in);
      line_code_in <= line_code_t'(c);
      straps_in <= strap_t'(6'h20);
      rst_n_in <= 1'h0;
      repeat (2) @(posedge clock_in);
      rst_n_in <= 1'h1;
      cnt = 0;
      @(posedge clock_in);
      for (int k = 0; k < 16; k++) begin
        step(1'h1, code_data[c][k], rail_pair_t'(2'h0),
             rail_pair_t'((k < 8) ? code_rails[c][15 - 2 * (k % 8) -: 2] : 2'h0));
        if (k >= 8) `CHK("coded rails", code_rails[c][31 - 2 * k -: 2], tx_rails_out)
        if (k >= 8) `CHK("decoded data", code_data[c][k - 8], rx_data_out)
      end
    end
    results();
  end
endmodule
`default_nettype wire
